//--- verilog/civc_pkg.sv
/*
  civc_pkg: shared constants and types for the comparator change
  interrupt and voltage reference ladder control block.
  Assumes an 8-bit register port and a 40 MHz system clock.
*/
package civc_pkg;
  // register byte offsets on the local register port
  localparam logic [7:0] CIVC_IRQCTL_OFF  = 8'h0b; // global and peripheral enables
  localparam logic [7:0] CIVC_FLAG_OFF    = 8'h0d; // peripheral flag register
  localparam logic [7:0] CIVC_ENABLE_OFF  = 8'h8d; // peripheral enable register
  localparam logic [7:0] CIVC_CMPCTL_OFF  = 8'h9c; // comparator control register
  localparam logic [7:0] CIVC_REFCTL_OFF  = 8'h9d; // reference control register

  // field positions
  localparam int CIVC_GLOB_EN_BIT   = 7; // global enable in irq control
  localparam int CIVC_PERIPH_EN_BIT = 6; // peripheral enable in irq control
  localparam int CIVC_CMF_BIT       = 6; // change flag / its enable
  localparam int CIVC_CMP_TWO_BIT   = 7; // comparator two output
  localparam int CIVC_CMP_ONE_BIT   = 6; // comparator one output
  localparam int CIVC_MODE_LSB      = 0; // comparator mode field

  // reset values and masks
  localparam logic [7:0] CIVC_REF_RST  = 8'h00; // all control cleared
  localparam logic [7:0] CIVC_REF_MASK = 8'hef; // bit 4 unimplemented
  localparam logic [2:0] CIVC_MODE_RST = 3'h7;  // comparators off
  localparam logic [2:0] CIVC_MODE_REF = 3'h6;  // mode using the ladder

  // reference fraction in 96ths of the source voltage
  localparam logic [6:0] CIVC_LOW_BASE = 7'h18; // one quarter = 24/96
  localparam logic [6:0] CIVC_LOW_STEP = 7'h03; // 1/32 = 3/96
  localparam logic [6:0] CIVC_HI_STEP  = 7'h04; // 1/24 = 4/96

  // reference control register layout
  typedef struct packed {
    logic       ladder_en;  // ladder powered
    logic       pin_oe;     // reference on shared pin
    logic       range_sel;  // 1: 0..0.625, 0: 0.25..0.71875
    logic       unused;     // reads zero
    logic [3:0] level_code; // tap select
  } civc_ref_t;

  // register port request bundle
  typedef struct packed {
    logic [7:0] addr;  // byte offset
    logic [7:0] wdata; // write data
    logic       wr;    // write strobe
    logic       rd;    // read strobe
  } civc_req_t;
endpackage

//--- verilog/civc_core.sv
/*
  civc_core: comparator change interrupt flag, enable gating and
  reference ladder control register, behind an 8-bit register port.
  Assumes: comparator outputs arrive asynchronously from the analog
  side; the master issues one-cycle strobes and takes read data in
  the following cycle; rstn is asynchronous, active low.
*/
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module civc_core
  import civc_pkg::*;
(
  input  wire logic       mclk,           // 40 MHz system clock
  input  wire logic       rstn,           // async reset, active low
  input  wire logic [7:0] reg_addr,       // register byte offset
  input  wire logic [7:0] reg_wdata,      // write data
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  output logic      [7:0] reg_rdata,      // read data, cycle after strobe
  input  wire logic       cmp_one_output, // comparator one, async
  input  wire logic       cmp_two_output, // comparator two, async
  output logic      [2:0] cmp_mode,       // comparator mode to analog
  output logic            ref_to_cmp,     // ladder feeds comparators
  output civc_ref_t       ref_ctrl,       // ladder control bits
  output logic      [6:0] ref_fraction,   // reference in 96ths
  output logic            irq             // level interrupt
);

  // request bundle
  civc_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // reference fraction in 96ths of the source voltage
  // a powered-down ladder reports zero; the analog side scales it
  function automatic logic [6:0] civc_frac(input civc_ref_t r);
    logic [6:0] lvl;
    lvl = {3'h0, r.level_code};
    if (!r.ladder_en) begin
      civc_frac = 7'h00;
    end else if (r.range_sel) begin
      civc_frac = 7'(lvl * CIVC_HI_STEP);
    end else begin
      civc_frac = 7'(CIVC_LOW_BASE + lvl * CIVC_LOW_STEP);
    end
  endfunction

  // two-stage synchronisers for the comparator outputs
  logic [1:0] cmp_meta_q;  // first stage, read by second only
  logic [1:0] cmp_sync_q;  // second stage, {two, one}

  // state registers
  logic [1:0] cmp_latch_q;  // copy held since last access
  logic       flag_q;       // cmp_change_flag
  logic       flag_d;
  logic       irq_en_q;     // cmp_irq_enable
  logic       periph_en_q;  // peripheral_irq_enable
  logic       glob_en_q;    // global_irq_enable
  logic [2:0] mode_q;       // comparator mode
  civc_ref_t  ref_q;        // comparator_reference_control
  logic [7:0] rdata_q;      // registered read data
  logic       irq_q;        // registered interrupt
  logic       ref_sel_q;    // ladder routed to comparators
  logic [6:0] frac_q;       // registered fraction

  // address decode
  wire sel_irqctl = (req.addr == CIVC_IRQCTL_OFF);
  wire sel_flag   = (req.addr == CIVC_FLAG_OFF);
  wire sel_enable = (req.addr == CIVC_ENABLE_OFF);
  wire sel_cmpctl = (req.addr == CIVC_CMPCTL_OFF);
  wire sel_refctl = (req.addr == CIVC_REFCTL_OFF);

  // any access to the comparator control register
  wire cmp_access = sel_cmpctl && (req.rd || req.wr);

  // live outputs differ from latched copy; held until an access
  // refreshes the copy, so a flag cleared early is set again
  wire mismatch = (cmp_sync_q != cmp_latch_q);

  // all four conditions for a level interrupt; the flag itself is
  // set regardless, so software can poll it with the enables off
  wire irq_cond = flag_q && irq_en_q && periph_en_q && glob_en_q;

  // ladder feeds the comparators only in mode 110
  wire ref_mode = (mode_q == CIVC_MODE_REF);

  // software write to the flag register
  wire flag_wr = req.wr && sel_flag;

  // read multiplexer, unmapped reads give zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sel_irqctl) begin
      rd_mux[CIVC_GLOB_EN_BIT]   = glob_en_q;
      rd_mux[CIVC_PERIPH_EN_BIT] = periph_en_q;
    end else if (sel_flag) begin
      rd_mux[CIVC_CMF_BIT] = flag_q;
    end else if (sel_enable) begin
      rd_mux[CIVC_CMF_BIT] = irq_en_q;
    end else if (sel_cmpctl) begin
      // outputs come from the synchroniser, never the raw pins
      rd_mux[CIVC_CMP_TWO_BIT] = cmp_sync_q[1];
      rd_mux[CIVC_CMP_ONE_BIT] = cmp_sync_q[0];
      rd_mux[CIVC_MODE_LSB +: 3] = mode_q;
    end else if (sel_refctl) begin
      rd_mux = ref_q & CIVC_REF_MASK;
    end
  end

  // flag next value: hardware set wins over software clear, so a
  // clear racing a standing mismatch is lost and must be repeated
  always_comb begin
    flag_d = flag_q;
    if (flag_wr) begin
      flag_d = req.wdata[CIVC_CMF_BIT];
    end
    if (mismatch) begin
      flag_d = 1'b1;
    end
  end

  // synchroniser chain; the first stage may go metastable and is
  // read by the second stage alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_meta_q <= 2'h0;
      cmp_sync_q <= 2'h0;
    end else begin
      cmp_meta_q <= {cmp_two_output, cmp_one_output};
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // latched copy: an access ends the mismatch; a change landing
  // in the same cycle still leaves a mismatch and is flagged
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_latch_q <= 2'h0;
    end else if (cmp_access) begin
      cmp_latch_q <= cmp_sync_q;
    end
  end

  // change flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // enable bits; all three must be set before the flag reaches irq
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      glob_en_q   <= 1'b0;
      periph_en_q <= 1'b0;
      irq_en_q    <= 1'b0;
    end else if (req.wr && sel_irqctl) begin
      glob_en_q   <= req.wdata[CIVC_GLOB_EN_BIT];
      periph_en_q <= req.wdata[CIVC_PERIPH_EN_BIT];
    end else if (req.wr && sel_enable) begin
      irq_en_q <= req.wdata[CIVC_CMF_BIT];
    end
  end

  // comparator mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= CIVC_MODE_RST;
    end else if (req.wr && sel_cmpctl) begin
      mode_q <= req.wdata[CIVC_MODE_LSB +: 3];
    end
  end

  // reference control, bit 4 forced low
  // so neither a read nor the outputs can show a stray one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= CIVC_REF_RST;
    end else if (req.wr && sel_refctl) begin
      ref_q <= req.wdata & CIVC_REF_MASK;
    end
  end

  // read data stands only in the cycle after the strobe and is
  // zero otherwise, so a stale value is never taken for a read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= req.rd ? rd_mux : 8'h00;
    end
  end

  // interrupt gating and ladder outputs
  // registered so that every output leaves a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_q     <= 1'b0;
      ref_sel_q <= 1'b0;
      frac_q    <= 7'h00;
    end else begin
      irq_q     <= irq_cond;
      ref_sel_q <= ref_mode;
      frac_q    <= civc_frac(ref_q);
    end
  end

  // outputs straight from flops
  assign reg_rdata    = rdata_q;
  assign irq          = irq_q;
  assign cmp_mode     = mode_q;
  assign ref_to_cmp   = ref_sel_q;
  assign ref_ctrl     = ref_q;
  assign ref_fraction = frac_q;

  // assertions guarding the flag, the interrupt and the ladder
  // every check runs on mclk and sleeps through reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // a standing mismatch sets the flag next cycle
  flag_set_a: assert property (mismatch |=> flag_q)
    else $error("change flag not set on mismatch");

  // control read returns synchronised outputs
  out_read_a: assert property (
    (req.rd && sel_cmpctl) |=> (reg_rdata[7:6] == $past(cmp_sync_q)))
    else $error("comparator outputs misread");

  // software write lands when no mismatch
  flag_write_a: assert property (
    (req.wr && sel_flag && !mismatch) |=>
      (flag_q == $past(req.wdata[CIVC_CMF_BIT])))
    else $error("flag write not taken");

  // all enables and flag give irq a cycle later
  irq_gate_a: assert property (
    (flag_q && irq_en_q && periph_en_q && glob_en_q) |=> irq)
    else $error("irq not raised");

  // global enable low blocks irq even with flag set
  irq_block_a: assert property (!glob_en_q |=> !irq)
    else $error("irq raised while globally disabled");

  // no flag, no interrupt
  irq_idle_a: assert property (!flag_q |=> !irq)
    else $error("irq raised without the change flag");

  // an access ends the mismatch by refreshing the copy
  miss_end_a: assert property (
    cmp_access |=> (cmp_latch_q == $past(cmp_sync_q)))
    else $error("access did not end mismatch");

  // flag held while mismatch persists despite clearing
  flag_hold_a: assert property (
    (mismatch && req.wr && sel_flag) |=> flag_q)
    else $error("clear beat a standing mismatch");

  // ladder routed a cycle after mode 110 is set
  ref_route_a: assert property (
    (mode_q == CIVC_MODE_REF) |=> ref_to_cmp)
    else $error("ladder not routed in mode 110");

  // reference write shows on the control outputs
  ref_write_a: assert property (
    (req.wr && sel_refctl) |=>
      (ref_ctrl == ($past(req.wdata) & CIVC_REF_MASK)))
    else $error("reference control write lost");

  // high range: fraction is code times four, two cycles on
  hi_range_a: assert property (
    (req.wr && sel_refctl && req.wdata[7] && req.wdata[5]) ##1
      !(req.wr && sel_refctl) |=>
      (ref_fraction == {1'b0, $past(ref_ctrl.level_code), 2'b00}))
    else $error("high range fraction wrong");

  // bit 4 reads zero
  rsvd_zero_a: assert property (
    (req.rd && sel_refctl) |=> !reg_rdata[4])
    else $error("unimplemented bit read as one");

  // ladder off gives zero fraction
  ladder_off_a: assert property (
    !ref_ctrl.ladder_en ##1 !ref_ctrl.ladder_en |-> ref_fraction == 7'h00)
    else $error("fraction nonzero with ladder off");

  // ladder released from the comparators in every other mode
  ref_off_a: assert property (
    (mode_q != CIVC_MODE_REF) |=> !ref_to_cmp)
    else $error("ladder routed outside mode 110");

  // read data returns to zero once its cycle has passed
  rdata_idle_a: assert property (!req.rd |=> (reg_rdata == 8'h00))
    else $error("read data stood beyond its cycle");

  // low range: a quarter plus three per code, two cycles on
  lo_range_a: assert property (
    (req.wr && sel_refctl && req.wdata[7] && !req.wdata[5]) ##1
      !(req.wr && sel_refctl) |=>
      (ref_fraction == 7'(CIVC_LOW_BASE + $past(ref_ctrl.level_code) * CIVC_LOW_STEP)))
    else $error("low range fraction wrong");

  // a set flag stays set until software writes to it
  flag_keep_a: assert property (
    (flag_q && !(req.wr && sel_flag)) |=> flag_q)
    else $error("change flag dropped without a write");

  // with no mismatch and no write the flag stays clear
  flag_quiet_a: assert property (
    (!flag_q && !mismatch && !(req.wr && sel_flag)) |=> !flag_q)
    else $error("change flag set with no output change");

  // the copy moves only on a control register access
  copy_hold_a: assert property (
    !cmp_access |=> $stable(cmp_latch_q))
    else $error("latched copy moved without an access");

  // unimplemented bit never holds a one
  rsvd_hold_a: assert property (!ref_ctrl.unused)
    else $error("unimplemented bit held a one");

  // pin enable follows bit six of a reference write
  pin_oe_a: assert property (
    (req.wr && sel_refctl) |=> (ref_ctrl.pin_oe == $past(req.wdata[6])))
    else $error("reference pin enable not taken");

  flag_cov_c: cover property (mismatch ##1 flag_q);
  irq_cov_c:  cover property (!irq ##1 irq);
  clr_cov_c:  cover property (cmp_access ##1 (req.wr && sel_flag) ##1 !flag_q);
  low_cov_c:  cover property (ref_ctrl.ladder_en && !ref_ctrl.range_sel);
  hold_cov_c: cover property (mismatch && flag_wr);

endmodule

//--- test/test_civc_core.sv
/*
  test_civc_core: self-checking bench for civc_core, the comparator change
  interrupt and reference ladder control block.
  Assumes the civc_pkg offsets, a 40 MHz mclk and an 8-bit register port
  with one-cycle strobes and read data in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module test_civc_core;
  import civc_pkg::*;
  logic       mclk;           // system clock
  logic       rstn;           // async reset, active low
  logic [7:0] reg_addr;       // register offset
  logic [7:0] reg_wdata;      // write data
  logic       reg_wr;         // write strobe
  logic       reg_rd;         // read strobe
  logic [7:0] reg_rdata;      // read data
  logic       cmp_one_output; // comparator one level
  logic       cmp_two_output; // comparator two level
  logic [2:0] cmp_mode;       // mode to analog side
  logic       ref_to_cmp;     // ladder routed to comparators
  civc_ref_t  ref_ctrl;       // ladder control bits
  logic [6:0] ref_fraction;   // reference in 96ths
  logic       irq;            // level interrupt
  int         err_count;      // mismatches seen
  int         checks_done;    // comparisons made
  logic [7:0] rd_val;         // last read result
  logic [7:0] v;              // reference control value

  civc_core i_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_one_output(cmp_one_output), .cmp_two_output(cmp_two_output),
    .cmp_mode(cmp_mode), .ref_to_cmp(ref_to_cmp), .ref_ctrl(ref_ctrl), .ref_fraction(ref_fraction), .irq(irq));

  // 25 ns period clock
  always #12.5 mclk = ~mclk;

  // byte comparison, counted
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // read and compare
  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    reg_read(a);
    check(rd_val, exp);
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq();
    int i;
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge mclk);
    #1 check({7'h00, irq}, 8'h01);
    if (irq !== 1'b1) test_done();
  endtask

  // main sequence
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cmp_one_output = 1'b0;
    cmp_two_output = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    // reset state
    read_check(CIVC_REFCTL_OFF, 8'h00);
    read_check(CIVC_CMPCTL_OFF, 8'h07);
    @(posedge mclk);
    #1 check(reg_rdata, 8'h00);
    check({7'h00, irq}, 8'h00);
    check({7'h00, ref_to_cmp}, 8'h00);
    read_check(8'h55, 8'h00);
    // unimplemented bit reads zero
    reg_write(CIVC_REFCTL_OFF, 8'hff);
    read_check(CIVC_REFCTL_OFF, 8'hef);
    // ladder powered down gives no reference
    reg_write(CIVC_REFCTL_OFF, 8'h6f);
    @(posedge mclk);
    #1 check({1'b0, ref_fraction}, 8'h00);
    check(ref_ctrl, 8'h6f);
    // every level code in both ranges
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        v = {1'b1, r[0], r[0], 1'b0, c[3:0]};
        reg_write(CIVC_REFCTL_OFF, v);
        @(posedge mclk);
        #1 check(ref_ctrl, v);
        check({1'b0, ref_fraction}, r ? 8'(c * 4) : 8'(24 + c * 3));
      end
    end
    // mode 110 routes the ladder
    reg_write(CIVC_CMPCTL_OFF, 8'h06);
    @(posedge mclk);
    #1 check({7'h00, ref_to_cmp}, 8'h01);
    check({5'h00, cmp_mode}, 8'h06);
    // change on comparator one raises flag and irq
    reg_write(CIVC_IRQCTL_OFF, 8'hc0);
    reg_write(CIVC_ENABLE_OFF, 8'h40);
    cmp_one_output <= 1'b1;
    wait_irq();
    read_check(CIVC_FLAG_OFF, 8'h40);
    read_check(CIVC_CMPCTL_OFF, 8'h46);
    reg_write(CIVC_FLAG_OFF, 8'h00);
    read_check(CIVC_FLAG_OFF, 8'h00);
    check({7'h00, irq}, 8'h00);
    // standing mismatch overrides a clear until the control register is read
    @(posedge mclk);
    cmp_two_output <= 1'b1;
    repeat (6) @(posedge mclk);
    reg_write(CIVC_FLAG_OFF, 8'h00);
    read_check(CIVC_FLAG_OFF, 8'h40);
    read_check(CIVC_CMPCTL_OFF, 8'hc6);
    reg_write(CIVC_FLAG_OFF, 8'h00);
    read_check(CIVC_FLAG_OFF, 8'h00);
    // software set with global enable off: flag only
    reg_write(CIVC_IRQCTL_OFF, 8'h40);
    reg_write(CIVC_FLAG_OFF, 8'h40);
    read_check(CIVC_FLAG_OFF, 8'h40);
    check({7'h00, irq}, 8'h00);
    reg_write(CIVC_IRQCTL_OFF, 8'h80);
    repeat (3) @(posedge mclk);
    #1 check({7'h00, irq}, 8'h00);
    reg_write(CIVC_IRQCTL_OFF, 8'hc0);
    wait_irq();
    // masked by the enable register
    reg_write(CIVC_ENABLE_OFF, 8'h00);
    repeat (3) @(posedge mclk);
    #1 check({7'h00, irq}, 8'h00);
    reg_write(CIVC_FLAG_OFF, 8'h00);
    read_check(CIVC_FLAG_OFF, 8'h00);
    // mid-run reset with both comparator outputs high
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1 check(ref_ctrl, 8'h00);
    check({5'h00, cmp_mode}, 8'h07);
    check({7'h00, ref_to_cmp}, 8'h00);
    check({7'h00, irq}, 8'h00);
    repeat (4) @(posedge mclk);
    read_check(CIVC_FLAG_OFF, 8'h40);
    read_check(CIVC_CMPCTL_OFF, 8'hc7);
    reg_write(CIVC_FLAG_OFF, 8'h00);
    read_check(CIVC_FLAG_OFF, 8'h00);
    test_done();
  end
endmodule
